// >>> design/irq_pkg.sv
// package: register map, bit positions and reset values of the interrupt block
package irq_pkg;
   // ****************************************************************
   // register byte addresses (printed offsets not all multiples of 4)
   // ****************************************************************
   localparam logic [7:0]  IDX_IRQ_CONTROL  = 8'h0B;
   localparam logic [7:0]  IDX_PERIPH_FLAG  = 8'h0C;
   localparam logic [7:0]  IDX_PERIPH_EN    = 8'h8C;
   localparam logic [7:0]  IDX_PIN_MASK     = 8'h96;
   localparam logic [7:0]  IDX_OPTIONS      = 8'h81;
   localparam logic [11:0] ADDR_IRQ_CONTROL = {2'h0, IDX_IRQ_CONTROL, 2'h0};
   localparam logic [11:0] ADDR_PERIPH_FLAG = {2'h0, IDX_PERIPH_FLAG, 2'h0};
   localparam logic [11:0] ADDR_PERIPH_EN   = {2'h0, IDX_PERIPH_EN, 2'h0};
   localparam logic [11:0] ADDR_PIN_MASK    = {2'h0, IDX_PIN_MASK, 2'h0};
   localparam logic [11:0] ADDR_OPTIONS     = {2'h0, IDX_OPTIONS, 2'h0};
   // ****************************************************************
   // control register bit positions, and the edge select bit of the options register
   // ****************************************************************
   localparam int GLOBAL_EN_BIT   = 7;
   localparam int PERIPH_GRP_BIT  = 6;
   localparam int T0_EN_BIT       = 5;
   localparam int EXT_EN_BIT      = 4;
   localparam int PORT_EN_BIT     = 3;
   localparam int T0_FLAG_BIT     = 2;
   localparam int EXT_FLAG_BIT    = 1;
   localparam int PORT_FLAG_BIT   = 0;
   localparam int EDGE_SEL_BIT    = 6;
   // ****************************************************************
   // peripheral register bit positions
   // ****************************************************************
   localparam int EE_BIT          = 7;
   localparam int LV_BIT          = 6;
   localparam int CR_BIT          = 5;
   localparam int CMPB_BIT        = 4;
   localparam int CMPA_BIT        = 3;
   localparam int OSC_BIT         = 2;
   localparam int T1_BIT          = 0;
   localparam logic [7:0] PERIPH_IMPL_MASK = 8'hFD;
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [7:0] RST_OPTIONS     = 8'hFF;
   localparam logic [7:0] CORE_EN_MASK    = 8'h38;
   localparam logic [7:0] CORE_FLAG_MASK  = 8'h07;
endpackage

// >>> design/edge_catch.sv
// module: per-bit change or selected-edge detector on synchronous inputs
`timescale 1ns/1ps
`default_nettype none
module edge_catch #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rstn_i,
   input  wire logic             keep_prev_i,
   input  wire logic [WIDTH-1:0] level_i,
   input  wire logic             any_change_i,
   input  wire logic             rise_sel_i,
   output logic      [WIDTH-1:0] event_o
);
   logic [WIDTH-1:0] prev_ff;
   logic [WIDTH-1:0] nxt_prev;

   if (WIDTH < 1) begin : g_bad_width
      $error("edge_catch width must be at least one");
   end

   // ****************************************************************
   // previous-level latch
   // ****************************************************************
   // keep_prev lets a soft reset keep tracking the level, so no edge flags at release
   always_comb begin
      nxt_prev = level_i;
      if (!rstn_i && !keep_prev_i) begin
         nxt_prev = '0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      prev_ff <= nxt_prev;
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         assign event_o[g] = any_change_i ? (level_i[g] ^ prev_ff[g]) :
                             rise_sel_i ? (level_i[g] & ~prev_ff[g]) :
                             (~level_i[g] & prev_ff[g]);
      end
   endgenerate
endmodule // edge_catch
`default_nettype wire

// >>> design/apb_regport.sv
// module: apb slave front end giving a one-cycle write strobe and registered read data
`timescale 1ns/1ps
`default_nettype none
module apb_regport (
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   input  wire logic [7:0]  rd_byte_i,
   input  wire logic        hit_i,
   output logic             pready_o,
   output logic [31:0]      prdata_o,
   output logic             pslverr_o,
   output logic             wr_stb_o,
   output logic [7:0]       wr_byte_o,
   output logic [11:0]      addr_o
);
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic        access;

   // ****************************************************************
   // zero-wait access phase
   // ****************************************************************
   assign access    = psel_i & penable_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = access & ~hit_i;
   assign addr_o    = paddr_i;
   // only the low byte lane carries register data
   assign wr_stb_o  = access & pwrite_i & hit_i & pstrb_i[0];
   assign wr_byte_o = pwdata_i[7:0];
   // read data sampled at setup, so it is in a flop by the access edge
   always_comb begin
      nxt_prdata = prdata_ff;
      if (!rstn_i) begin
         nxt_prdata = 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         nxt_prdata = {24'h00_0000, rd_byte_i};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      prdata_ff <= nxt_prdata;
   end

   assign prdata_o = prdata_ff;
endmodule // apb_regport
`default_nettype wire

// >>> design/irq_flag_enable.sv
// module: interrupt flag and enable logic with apb register access
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_enable #(
   parameter int  PINS      = 6,
   parameter bit  HAS_CMP_B = 1'b1
) (
   input  wire logic            ref_clk_i,
   input  wire logic            rstn_i,
   input  wire logic            power_on_i,
   input  wire logic            psel_i,
   input  wire logic            penable_i,
   input  wire logic            pwrite_i,
   input  wire logic [11:0]     paddr_i,
   input  wire logic [31:0]     pwdata_i,
   input  wire logic [3:0]      pstrb_i,
   output logic                 pready_o,
   output logic [31:0]          prdata_o,
   output logic                 pslverr_o,
   input  wire logic            timer0_ovf_i,
   input  wire logic            ext_irq_pin_i,
   input  wire logic [PINS-1:0] port_pins_i,
   input  wire logic            eeprom_done_i,
   input  wire logic            low_volt_i,
   input  wire logic            crypto_done_i,
   input  wire logic            comparator_b_output_i,
   input  wire logic            comparator_a_output_i,
   input  wire logic            osc_fail_i,
   input  wire logic            timer1_roll_i,
   output logic                 irq_req_o
);
   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0]      ctrl_ff;
   logic [7:0]      nxt_ctrl;
   logic [7:0]      pflag_ff;
   logic [7:0]      nxt_pflag;
   logic [7:0]      pen_ff;
   logic [7:0]      nxt_pen;
   logic [PINS-1:0] mask_ff;
   logic [PINS-1:0] nxt_mask;
   logic [7:0]      opt_ff;
   logic [7:0]      nxt_opt;
   logic            irq_ff;
   logic            nxt_irq;

   logic            wr_stb;
   logic [7:0]      wr_byte;
   logic [11:0]     addr;
   logic [7:0]      rd_byte;
   logic            hit;
   logic [PINS-1:0] pin_evt;
   logic [0:0]      ext_evt;
   logic [1:0]      cmp_evt;
   logic [1:0]      cmp_lvl;
   logic [7:0]      core_set;
   logic [7:0]      per_set;
   logic [7:0]      byte_zero;
   logic            core_hit;
   logic            per_hit;

   // every check runs on the one clock and rests during reset
   default clocking cb_chk @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);

   if (PINS < 1 || PINS > 8) begin : g_bad_pins
      $error("PINS must be 1 to 8");
   end

   assign byte_zero = 8'h00;

   // ****************************************************************
   // bus front end and read mux
   // ****************************************************************
   apb_regport u_bus (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pwrite_i  (pwrite_i),
      .paddr_i   (paddr_i),
      .pwdata_i  (pwdata_i),
      .pstrb_i   (pstrb_i),
      .rd_byte_i (rd_byte),
      .hit_i     (hit),
      .pready_o  (pready_o),
      .prdata_o  (prdata_o),
      .pslverr_o (pslverr_o),
      .wr_stb_o  (wr_stb),
      .wr_byte_o (wr_byte),
      .addr_o    (addr)
   );

   always_comb begin
      rd_byte = 8'h00;
      hit     = 1'b1;
      case (addr)
         irq_pkg::ADDR_IRQ_CONTROL: rd_byte = ctrl_ff;
         irq_pkg::ADDR_PERIPH_FLAG: rd_byte = pflag_ff;
         irq_pkg::ADDR_PERIPH_EN:   rd_byte = pen_ff;
         irq_pkg::ADDR_PIN_MASK: begin
            rd_byte = byte_zero;
            rd_byte[PINS-1:0] = mask_ff;
         end
         irq_pkg::ADDR_OPTIONS:     rd_byte = opt_ff;
         default:                   hit = 1'b0;
      endcase
   end

   // ****************************************************************
   // event detectors
   // ****************************************************************
   edge_catch #(.WIDTH(PINS)) u_pins (
      .ref_clk_i    (ref_clk_i),
      .rstn_i       (rstn_i),
      .keep_prev_i  (~power_on_i),
      .level_i      (port_pins_i),
      .any_change_i (1'b1),
      .rise_sel_i   (1'b0),
      .event_o      (pin_evt)
   );

   // tracking the level through reset avoids a false edge at release
   edge_catch #(.WIDTH(1)) u_ext (
      .ref_clk_i    (ref_clk_i),
      .rstn_i       (rstn_i),
      .keep_prev_i  (1'b1),
      .level_i      (ext_irq_pin_i),
      .any_change_i (1'b0),
      .rise_sel_i   (opt_ff[irq_pkg::EDGE_SEL_BIT]),
      .event_o      (ext_evt)
   );

   assign cmp_lvl = {comparator_b_output_i & HAS_CMP_B,
                     comparator_a_output_i};

   edge_catch #(.WIDTH(2)) u_cmp (
      .ref_clk_i    (ref_clk_i),
      .rstn_i       (rstn_i),
      .keep_prev_i  (1'b1),
      .level_i      (cmp_lvl),
      .any_change_i (1'b1),
      .rise_sel_i   (1'b0),
      .event_o      (cmp_evt)
   );

   // ****************************************************************
   // set vectors
   // ****************************************************************
   always_comb begin
      core_set = 8'h00;
      core_set[irq_pkg::T0_FLAG_BIT]   = timer0_ovf_i;
      core_set[irq_pkg::EXT_FLAG_BIT]  = ext_evt[0];
      core_set[irq_pkg::PORT_FLAG_BIT] = |(pin_evt & mask_ff);
      per_set = 8'h00;
      per_set[irq_pkg::EE_BIT]   = eeprom_done_i;
      per_set[irq_pkg::LV_BIT]   = low_volt_i;
      per_set[irq_pkg::CR_BIT]   = crypto_done_i;
      per_set[irq_pkg::CMPB_BIT] = cmp_evt[1];
      per_set[irq_pkg::CMPA_BIT] = cmp_evt[0];
      per_set[irq_pkg::OSC_BIT]  = osc_fail_i;
      per_set[irq_pkg::T1_BIT]   = timer1_roll_i;
   end

   // ****************************************************************
   // register next values; set wins over a software clear
   // ****************************************************************
   always_comb begin
      nxt_ctrl  = ctrl_ff;
      nxt_pflag = pflag_ff;
      nxt_pen   = pen_ff;
      nxt_mask  = mask_ff;
      nxt_opt   = opt_ff;
      if (wr_stb && addr == irq_pkg::ADDR_IRQ_CONTROL) begin
         nxt_ctrl = wr_byte;
      end
      if (wr_stb && addr == irq_pkg::ADDR_PERIPH_FLAG) begin
         nxt_pflag = wr_byte & irq_pkg::PERIPH_IMPL_MASK;
      end
      if (wr_stb && addr == irq_pkg::ADDR_PERIPH_EN) begin
         nxt_pen = wr_byte & irq_pkg::PERIPH_IMPL_MASK;
      end
      if (wr_stb && addr == irq_pkg::ADDR_PIN_MASK) begin
         nxt_mask = wr_byte[PINS-1:0];
      end
      if (wr_stb && addr == irq_pkg::ADDR_OPTIONS) begin
         nxt_opt = wr_byte;
      end
      // events set flags whatever the enables say
      nxt_ctrl  = nxt_ctrl | core_set;
      nxt_pflag = (nxt_pflag | per_set) & irq_pkg::PERIPH_IMPL_MASK;
      if (!rstn_i) begin
         // timer0 flag survives reset; software must initialise it
         nxt_ctrl = irq_pkg::RST_BYTE;
         nxt_ctrl[irq_pkg::T0_FLAG_BIT] =
            ctrl_ff[irq_pkg::T0_FLAG_BIT];
         nxt_ctrl[irq_pkg::PORT_FLAG_BIT] = 1'b0;
         nxt_pflag = irq_pkg::RST_BYTE;
         nxt_pen   = irq_pkg::RST_BYTE;
         nxt_mask  = '0;
         nxt_opt   = irq_pkg::RST_OPTIONS;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      ctrl_ff  <= nxt_ctrl;
      pflag_ff <= nxt_pflag;
      pen_ff   <= nxt_pen;
      mask_ff  <= nxt_mask;
      opt_ff   <= nxt_opt;
   end

   // ****************************************************************
   // request to the cpu
   // ****************************************************************
   // flag bits 2..0 pair with enable bits 5..3
   assign core_hit = |((ctrl_ff & irq_pkg::CORE_EN_MASK) >>
                       irq_pkg::PORT_EN_BIT &
                       ctrl_ff & irq_pkg::CORE_FLAG_MASK);
   assign per_hit  = ctrl_ff[irq_pkg::PERIPH_GRP_BIT] &
                     |(pflag_ff & pen_ff);

   always_comb begin
      nxt_irq = ctrl_ff[irq_pkg::GLOBAL_EN_BIT] &
                (core_hit | per_hit);
      if (!rstn_i) begin
         nxt_irq = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      irq_ff <= nxt_irq;
   end

   assign irq_req_o = irq_ff;

   // ****************************************************************
   // checks
   // ****************************************************************
   // an armed source must become a request one edge later
   sequence seq_core_armed;
      ctrl_ff[irq_pkg::GLOBAL_EN_BIT] && core_hit;
   endsequence
   sequence seq_periph_armed;
      ctrl_ff[irq_pkg::GLOBAL_EN_BIT] && per_hit;
   endsequence

   chk_req_gated: assert property (
      !ctrl_ff[irq_pkg::GLOBAL_EN_BIT] |=> !irq_req_o)
      else $error("request raised with global enable low");
   chk_periph_group: assert property (
      (!ctrl_ff[irq_pkg::PERIPH_GRP_BIT] && !core_hit) |=> !irq_req_o)
      else $error("peripheral request passed with group enable low");
   chk_req_follows: assert property (
      seq_core_armed |=> irq_req_o)
      else $error("core request not raised");
   chk_periph_req: assert property (
      seq_periph_armed |=> irq_req_o)
      else $error("peripheral request not raised");
   chk_timer0_set: assert property (
      timer0_ovf_i |=> ctrl_ff[irq_pkg::T0_FLAG_BIT])
      else $error("timer0 flag missed an overflow");
   chk_ext_set: assert property (
      ext_evt[0] |=> ctrl_ff[irq_pkg::EXT_FLAG_BIT])
      else $error("external pin flag missed an edge");
   chk_periph_set: assert property (
      timer1_roll_i |=> pflag_ff[irq_pkg::T1_BIT])
      else $error("timer1 flag missed a rollover");
   chk_eeprom_set: assert property (
      eeprom_done_i |=> pflag_ff[irq_pkg::EE_BIT])
      else $error("eeprom flag missed a done event");
   chk_cmp_set: assert property (
      cmp_evt[0] |=> pflag_ff[irq_pkg::CMPA_BIT])
      else $error("comparator flag missed a change");
   chk_bit1_zero: assert property (
      ((pflag_ff | pen_ff) & ~irq_pkg::PERIPH_IMPL_MASK) == 8'h00)
      else $error("unimplemented bit reads one");
   chk_port_set: assert property (
      |(pin_evt & mask_ff) |=> ctrl_ff[irq_pkg::PORT_FLAG_BIT])
      else $error("port change flag missed");
   chk_flag_sticky: assert property (
      (pflag_ff[irq_pkg::LV_BIT] && !wr_stb) |=> pflag_ff[irq_pkg::LV_BIT])
      else $error("low voltage flag dropped without a write");
endmodule // irq_flag_enable
`default_nettype wire

// >>> verif/event_src.sv
// partner model: event sources that feed the interrupt block
`timescale 1ns/1ps
`default_nettype none
module event_src (
   input  wire logic       ref_clk_i,
   input  wire logic [8:0] fire_i,
   input  wire logic [5:0] pin_tog_i,
   output logic            timer0_ovf_o,
   output logic            ext_irq_pin_o,
   output logic [5:0]      port_pins_o,
   output logic            eeprom_done_o,
   output logic            low_volt_o,
   output logic            crypto_done_o,
   output logic            comparator_b_output_o,
   output logic            comparator_a_output_o,
   output logic            osc_fail_o,
   output logic            timer1_roll_o
);
   // ****************************************************************
   // pulses for done events, toggles for level sources
   // ****************************************************************
   logic [5:0] pulse_ff = 6'h00;
   logic [2:0] lvl_ff   = 3'h0;
   logic [5:0] pins_ff  = 6'h00;
   // one-cycle pulses; the flag must latch them on its own
   always_ff @(posedge ref_clk_i) begin
      pulse_ff <= {fire_i[8], fire_i[7], fire_i[4:2], fire_i[0]};
      lvl_ff   <= lvl_ff ^ {fire_i[6], fire_i[5], fire_i[1]};
      pins_ff  <= pins_ff ^ pin_tog_i;
   end
   assign timer0_ovf_o          = pulse_ff[0];
   assign eeprom_done_o         = pulse_ff[1];
   assign low_volt_o            = pulse_ff[2];
   assign crypto_done_o         = pulse_ff[3];
   assign osc_fail_o            = pulse_ff[4];
   assign timer1_roll_o         = pulse_ff[5];
   assign ext_irq_pin_o         = lvl_ff[0];
   assign comparator_b_output_o = lvl_ff[1];
   assign comparator_a_output_o = lvl_ff[2];
   assign port_pins_o           = pins_ff;
endmodule // event_src
`default_nettype wire

// >>> verif/tb_irq_flag_enable.sv
// testbench: interrupt flag and enable block through apb and events
`timescale 1ns/1ps
`default_nettype none
module tb_irq_flag_enable;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic        ref_clk = 1'b0, rstn = 1'b0, power_on = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic [3:0]  pstrb = 4'hF, strb_use = 4'hF;
   logic        pready, pslverr, irq_req, e;
   logic [8:0]  fire = 9'h000;
   logic [5:0]  pin_tog = 6'h00, pins_w;
   logic        t0_w, ext_w, ee_w, lv_w, cr_w, cb_w, ca_w, os_w, t1_w;
   int          miscompares = 0, n_checks = 0, cyc = 0;
   localparam logic [11:0] CT = irq_pkg::ADDR_IRQ_CONTROL;
   localparam logic [11:0] PF = irq_pkg::ADDR_PERIPH_FLAG;
   localparam logic [11:0] PE = irq_pkg::ADDR_PERIPH_EN;
   typedef struct {
      logic [8:0]  f;
      logic [5:0]  p;
      logic [11:0] a;
      logic [7:0]  x;
   } row_s;
   row_s rows [11];
   irq_flag_enable dut (.ref_clk_i(ref_clk), .rstn_i(rstn),
      .power_on_i(power_on), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata),
      .pslverr_o(pslverr), .timer0_ovf_i(t0_w), .ext_irq_pin_i(ext_w),
      .port_pins_i(pins_w), .eeprom_done_i(ee_w), .low_volt_i(lv_w),
      .crypto_done_i(cr_w), .comparator_b_output_i(cb_w),
      .comparator_a_output_i(ca_w), .osc_fail_i(os_w),
      .timer1_roll_i(t1_w), .irq_req_o(irq_req));
   event_src src (.ref_clk_i(ref_clk), .fire_i(fire), .pin_tog_i(pin_tog),
      .timer0_ovf_o(t0_w), .ext_irq_pin_o(ext_w), .port_pins_o(pins_w),
      .eeprom_done_o(ee_w), .low_volt_o(lv_w), .crypto_done_o(cr_w),
      .comparator_b_output_o(cb_w), .comparator_a_output_o(ca_w),
      .osc_fail_o(os_w), .timer1_roll_o(t1_w));
   // ****************************************************************
   // clock, timeout and shared tasks
   // ****************************************************************
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   // ceiling well above the few hundred cycles the tests need
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x,
                      input string what);
      n_checks++;
      if (s !== x) begin
         miscompares++;
         $display("mismatch at %0t: %s seen %h exp %h", $time, what, s, x);
      end
   endtask
   // apb access; the wait has no bound of its own, the timeout ends a hang
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [7:0] v);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, v};
      pstrb   <= strb_use;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      xfer(1'b1, a, v);
   endtask
   task automatic rd(input logic [11:0] a);
      xfer(1'b0, a, 8'h00);
   endtask
   task automatic fire_ev(input logic [8:0] f, input logic [5:0] p);
      @(posedge ref_clk);
      fire    <= f;
      pin_tog <= p;
      @(posedge ref_clk);
      fire    <= 9'h000;
      pin_tog <= 6'h00;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic irq_is(input logic x);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq_req}, {31'h0, x}, "irq request");
   endtask
   task automatic do_reset(input logic po);
      @(posedge ref_clk);
      rstn     <= 1'b0;
      power_on <= po;
      repeat (20) @(posedge ref_clk);
      rstn     <= 1'b1;
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      rows = '{'{9'h001, 6'h00, CT, 8'h04}, '{9'h002, 6'h00, CT, 8'h02},
               '{9'h000, 6'h01, CT, 8'h01}, '{9'h000, 6'h02, CT, 8'h00},
               '{9'h004, 6'h00, PF, 8'h80}, '{9'h008, 6'h00, PF, 8'h40},
               '{9'h010, 6'h00, PF, 8'h20}, '{9'h020, 6'h00, PF, 8'h10},
               '{9'h040, 6'h00, PF, 8'h08}, '{9'h080, 6'h00, PF, 8'h04},
               '{9'h100, 6'h00, PF, 8'h01}};
      do_reset(1'b1);
      rd(CT);
      chk(d & 32'hFB, 32'h0, "control reset");
      rd(PF);
      chk(d, 32'h0, "flag reset");
      rd(PE);
      chk(d, 32'h0, "enable reset");
      wr(irq_pkg::ADDR_PIN_MASK, 8'h01);
      foreach (rows[i]) begin
         wr(CT, 8'h00);
         wr(PF, 8'h00);
         fire_ev(rows[i].f, rows[i].p);
         rd(rows[i].a);
         if (rows[i].a == CT)
            chk(d, 32'(rows[i].x), "ct");
         else
            chk(d, 32'(rows[i].x), "pf");
      end
      $display("test rows done");
      wr(PF, 8'hFF);
      rd(PF);
      chk(d, 32'hFD, "flag bit1");
      wr(PE, 8'hFF);
      rd(PE);
      chk(d, 32'hFD, "enable bit1");
      strb_use = 4'hE;
      wr(PE, 8'h00);
      strb_use = 4'hF;
      rd(PE);
      chk(d, 32'hFD, "masked strobe");
      rd(12'h3FC);
      chk({31'h0, e}, 32'h1, "unmapped error");
      chk(d, 32'h0, "unmapped data");
      $display("test access done");
      wr(CT, 8'h00);
      wr(PF, 8'h00);
      wr(PE, 8'h00);
      fire_ev(9'h001, 6'h00);
      wr(CT, 8'h24);
      irq_is(1'b0);
      wr(CT, 8'hA4);
      irq_is(1'b1);
      wr(CT, 8'h84);
      irq_is(1'b0);
      wr(CT, 8'h00);
      // flag cleared before its enable is raised
      wr(PF, 8'h00);
      wr(PE, 8'h01);
      fire_ev(9'h100, 6'h00);
      wr(CT, 8'h80);
      irq_is(1'b0);
      wr(CT, 8'hC0);
      irq_is(1'b1);
      wr(PE, 8'h00);
      irq_is(1'b0);
      wr(PE, 8'h01);
      wr(CT, 8'h40);
      irq_is(1'b0);
      $display("test gating done");
      wr(irq_pkg::ADDR_OPTIONS, 8'h00);
      wr(CT, 8'h00);
      fire_ev(9'h002, 6'h00);
      rd(CT);
      chk(d, 32'h02, "falling edge");
      wr(CT, 8'h00);
      fire_ev(9'h002, 6'h00);
      rd(CT);
      chk(d, 32'h00, "rising ignored");
      $display("test edge done");
      wr(CT, 8'h04);
      fire_ev(9'h000, 6'h01);
      rd(CT);
      chk(d, 32'h05, "port flag set");
      do_reset(1'b0);
      rd(CT);
      chk(d, 32'h04, "soft reset");
      do_reset(1'b1);
      rd(CT);
      chk(d, 32'h04, "power reset");
      rd(irq_pkg::ADDR_OPTIONS);
      chk(d, 32'hFF, "options reset");
      $display("test reset done");
      give_verdict();
   end
endmodule // tb_irq_flag_enable
`default_nettype wire
